/* File: core/flash_status_two_regs.svh */
`ifndef FLASH_STATUS_TWO_REGS_SVH
`define FLASH_STATUS_TWO_REGS_SVH

// Bit positions inside the second status register.
`define BIT_COMPLEMENT 6
`define BIT_LOCK_HI 5
`define BIT_LOCK_LO 3
`define BIT_RESERVED 2
`define BIT_FOUR_LANE 1
`define BIT_GUARD_HIGH 0

// Reset values of the writable fields, and the factory value of the lock flags.
`define RST_COMPLEMENT 1'h0
`define RST_FOUR_LANE 1'h0
`define RST_GUARD_HIGH 1'h0
`define RST_LOCKS 3'h0

// Security registers are 128 bytes; the last byte index locks them.
`define SEC_LAST_BYTE 7'h7F
`define SEC_FACTORY_REG 2'h0

// Serial command opcodes.
`define OP_READ_SR2 8'h35
`define OP_WRITE_SR2 8'h31
`define OP_WRITE_ENABLE 8'h06
`define OP_QUAD_OUT_READ 8'h6B
`define OP_FETCH_READ 8'hEB
`define OP_WORD_QUAD_READ 8'hE7
`define OP_QUAD_PROGRAM 8'h32
`define OP_BURST_WRAP 8'h77
`define OP_QUAD_ID 8'h94

// Guard encodings {high, low}.
`define GUARD_SOFT 2'h0
`define GUARD_PIN 2'h1
`define GUARD_RESET 2'h2
`define GUARD_FULL 2'h3

`endif

/* File: core/flash_status_two_pkg.sv */
package flash_status_two_pkg;

    typedef enum logic [1:0] {
        st_opcode,
        st_data,
        st_idle
    } link_state_t;

    typedef struct packed {
        logic complement_protect_flag;
        logic [2:0] security_lock_flags;
        logic four_lane_enable;
        logic status_guard_high;
    } status_two_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } write_req_t;

endpackage

/* File: core/region_guard.sv */
`timescale 1ns/100ps
`default_nettype none
`include "flash_status_two_regs.svh"

// Combines the block-protect selection with the complement flag and the
// security lock state into the final program/erase permission.
module region_guard (
    input wire logic region_selected,
    input wire logic complement_protect_flag,
    input wire logic is_security_access,
    input wire logic [1:0] security_index,
    input wire logic [2:0] security_lock_flags,
    output logic write_blocked
);
    logic array_blocked;
    logic sec_blocked;

    // The selection itself is untouched; only its sense is flipped.
    assign array_blocked = region_selected ^ complement_protect_flag;

    always_comb begin
        if (security_index == `SEC_FACTORY_REG) begin
            sec_blocked = 1'b1;
        end else begin
            sec_blocked = security_lock_flags[security_index - 2'h1];
        end
    end

    assign write_blocked = is_security_access ? sec_blocked : array_blocked;

endmodule
`default_nettype wire

/* File: core/status_two_bank.sv */
`timescale 1ns/100ps
`default_nettype none
`include "flash_status_two_regs.svh"

module status_two_bank (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic chip_select_n,
    input wire logic link_mosi,
    output logic link_miso,
    output logic link_miso_oe_n,
    input wire logic write_guard_pin_n,
    input wire logic pause_pin_n,
    input wire logic status_guard_low,
    input wire logic status_guard_permanent,
    input wire logic write_enable_latch,
    input wire logic region_selected,
    input wire logic sec_program_pulse,
    input wire logic [1:0] sec_program_index,
    input wire logic [6:0] sec_program_byte,
    input wire logic [7:0] opcode_seen,
    input wire logic opcode_valid,
    output logic sec_write_blocked,
    output logic array_write_blocked,
    output logic command_allowed,
    output logic guard_pin_active,
    output logic pause_pin_active,
    output logic quad_lanes_active,
    output logic [7:0] status_two_value
);
    flash_status_two_pkg::status_two_t regs;
    flash_status_two_pkg::link_state_t link_state;
    flash_status_two_pkg::write_req_t link_req;

    logic [2:0] bit_count;
    logic [7:0] shift_in;
    logic [7:0] opcode;
    logic [7:0] read_shadow;
    logic [7:0] read_shift;
    // Power-up value only: the link clock stops between frames, so the
    // toggle cannot be reset from that side.
    logic req_toggle = 1'b0;
    logic [7:0] req_data;
    logic req_is_write;
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic [7:0] sr2_sync_a;
    logic [7:0] sr2_sync_b;
    logic wp_sync_a;
    logic wp_sync_b;
    logic hold_sync_a;
    logic hold_sync_b;
    logic status_writable;
    logic quad_command;
    logic lock_event;
    logic [2:0] lock_set;
    logic sec_blocked_raw;
    logic array_blocked_raw;
    logic permanent_lock;

    // ---- Link domain: shift opcode and one data byte in on link_clk. ----
    always_ff @(posedge link_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            bit_count <= 3'h0;
            link_state <= flash_status_two_pkg::st_opcode;
            shift_in <= 8'h00;
            opcode <= 8'h00;
        end else begin
            shift_in <= {shift_in[6:0], link_mosi};
            bit_count <= bit_count + 3'h1;
            if (bit_count == 3'h7) begin
                case (link_state)
                    flash_status_two_pkg::st_opcode: begin
                        opcode <= {shift_in[6:0], link_mosi};
                        link_state <= flash_status_two_pkg::st_data;
                    end
                    flash_status_two_pkg::st_data: begin
                        link_state <= flash_status_two_pkg::st_idle;
                    end
                    default: begin
                        link_state <= flash_status_two_pkg::st_idle;
                    end
                endcase
            end
        end
    end

    // A completed write byte is handed over as a toggle plus stable data;
    // the data is held until the next frame, long after the toggle syncs.
    always_ff @(posedge link_clk) begin
        if (!chip_select_n && bit_count == 3'h7 &&
            link_state == flash_status_two_pkg::st_data &&
            opcode == `OP_WRITE_SR2) begin
            req_data <= {shift_in[6:0], link_mosi};
            req_toggle <= ~req_toggle;
        end
    end

    // Read data: sample the synchronised status image at the opcode end.
    always_ff @(negedge link_clk) begin
        if (!chip_select_n && bit_count == 3'h0 &&
            link_state == flash_status_two_pkg::st_data) begin
            read_shift <= sr2_sync_b;
        end else begin
            read_shift <= {read_shift[6:0], 1'b0};
        end
    end

    always_comb begin
        link_miso = read_shift[7];
        link_miso_oe_n = ~(!chip_select_n && opcode == `OP_READ_SR2 &&
            link_state != flash_status_two_pkg::st_opcode);
    end

    // Status image crossing into the link domain; it changes rarely and
    // only between frames in normal use.
    always_ff @(posedge link_clk) begin
        sr2_sync_a <= read_shadow;
        sr2_sync_b <= sr2_sync_a;
    end

    // ---- System domain. ----
    // The toggle synchroniser keeps running through reset. Clearing it
    // would replay the last link write as soon as reset lets go.
    always_ff @(posedge clk_sys) begin
        sync_a <= req_toggle;
        sync_b <= sync_a;
        sync_c <= sync_b;
    end

    always_ff @(posedge clk_sys) begin
        wp_sync_a <= write_guard_pin_n;
        wp_sync_b <= wp_sync_a;
        hold_sync_a <= pause_pin_n;
        hold_sync_b <= hold_sync_a;
    end

    assign req_is_write = sync_b ^ sync_c;
    assign link_req.valid = req_is_write;
    assign link_req.data = req_data;

    // Status write permission from the guard bits and the pin.
    always_comb begin
        case ({regs.status_guard_high, status_guard_low})
            `GUARD_SOFT: status_writable = write_enable_latch;
            `GUARD_PIN: status_writable = write_enable_latch &&
                (wp_sync_b || regs.four_lane_enable);
            `GUARD_RESET: status_writable = 1'b0;
            default: status_writable = 1'b0;
        endcase
    end

    assign lock_event = sec_program_pulse &&
        sec_program_byte == `SEC_LAST_BYTE &&
        sec_program_index != `SEC_FACTORY_REG && !sec_blocked_raw;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_lock
            assign lock_set[gi] = lock_event &&
                sec_program_index == 2'(gi + 1);
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            regs.complement_protect_flag <= `RST_COMPLEMENT;
            regs.four_lane_enable <= `RST_FOUR_LANE;
        end else if (link_req.valid && status_writable) begin
            regs.complement_protect_flag <=
                link_req.data[`BIT_COMPLEMENT];
            regs.four_lane_enable <= link_req.data[`BIT_FOUR_LANE];
        end
    end

    // Guard high: reset clears it unless the permanent lock holds it.
    assign permanent_lock = regs.status_guard_high && status_guard_low &&
        status_guard_permanent;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            if (!permanent_lock) begin
                regs.status_guard_high <= `RST_GUARD_HIGH;
            end
        end else if (link_req.valid && status_writable) begin
            regs.status_guard_high <= link_req.data[`BIT_GUARD_HIGH];
        end
    end

    // Lock flags are one-time: reset does not clear them, only the
    // factory value initialises them, and software can never write them.
    initial regs.security_lock_flags = `RST_LOCKS;
    always_ff @(posedge clk_sys) begin
        regs.security_lock_flags <= regs.security_lock_flags | lock_set;
    end

    always_comb begin
        read_shadow = 8'h00;
        read_shadow[`BIT_COMPLEMENT] = regs.complement_protect_flag;
        read_shadow[`BIT_LOCK_HI:`BIT_LOCK_LO] =
            regs.security_lock_flags;
        read_shadow[`BIT_FOUR_LANE] = regs.four_lane_enable;
        read_shadow[`BIT_GUARD_HIGH] = regs.status_guard_high;
    end

    always_comb begin
        case (opcode_seen)
            `OP_QUAD_OUT_READ, `OP_FETCH_READ, `OP_WORD_QUAD_READ,
            `OP_QUAD_PROGRAM, `OP_BURST_WRAP, `OP_QUAD_ID:
                quad_command = 1'b1;
            default: quad_command = 1'b0;
        endcase
    end

    region_guard u_sec (
        .region_selected(1'b0),
        .complement_protect_flag(1'b0),
        .is_security_access(1'b1),
        .security_index(sec_program_index),
        .security_lock_flags(regs.security_lock_flags),
        .write_blocked(sec_blocked_raw)
    );

    region_guard u_array (
        .region_selected(region_selected),
        .complement_protect_flag(regs.complement_protect_flag),
        .is_security_access(1'b0),
        .security_index(2'h0),
        .security_lock_flags(regs.security_lock_flags),
        .write_blocked(array_blocked_raw)
    );

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            command_allowed <= 1'b0;
            sec_write_blocked <= 1'b1;
            array_write_blocked <= 1'b0;
            status_two_value <= 8'h00;
        end else begin
            command_allowed <= opcode_valid &&
                (!quad_command || regs.four_lane_enable);
            sec_write_blocked <= sec_blocked_raw;
            array_write_blocked <= array_blocked_raw;
            status_two_value <= read_shadow;
        end
    end

    always_comb begin
        quad_lanes_active = regs.four_lane_enable;
        guard_pin_active = !regs.four_lane_enable && !wp_sync_b;
        pause_pin_active = !regs.four_lane_enable && !hold_sync_b;
    end

    property p_lock_sticky;
        @(posedge clk_sys) disable iff (sys_rst)
        1'b1 |=> (regs.security_lock_flags &
            $past(regs.security_lock_flags)) ==
            $past(regs.security_lock_flags);
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock flag cleared");

    property p_factory_blocked;
        @(posedge clk_sys) disable iff (sys_rst)
        sec_program_index == `SEC_FACTORY_REG |-> ##1 sec_write_blocked;
    endproperty
    a_factory_blocked: assert property (p_factory_blocked)
        else $error("factory register writable");

    property p_reserved_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        ##1 status_two_value[`BIT_RESERVED] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit set");

    property p_complement;
        @(posedge clk_sys) disable iff (sys_rst)
        1'b1 |=> array_write_blocked == $past(region_selected ^
            regs.complement_protect_flag);
    endproperty
    a_complement: assert property (p_complement)
        else $error("complement not applied");

    property p_quad_gate;
        @(posedge clk_sys) disable iff (sys_rst)
        opcode_valid && quad_command && !regs.four_lane_enable
            |=> !command_allowed;
    endproperty
    a_quad_gate: assert property (p_quad_gate)
        else $error("quad command not gated");

    property p_reset_lock;
        @(posedge clk_sys) disable iff (sys_rst)
        regs.status_guard_high && link_req.valid
            |=> $stable(regs.four_lane_enable) &&
            $stable(regs.complement_protect_flag);
    endproperty
    a_reset_lock: assert property (p_reset_lock)
        else $error("locked status written");

    property p_pins;
        @(posedge clk_sys) disable iff (sys_rst)
        regs.four_lane_enable |-> !guard_pin_active && !pause_pin_active;
    endproperty
    a_pins: assert property (p_pins)
        else $error("control pin active in quad mode");

    property p_guard_reset;
        @(posedge clk_sys)
        sys_rst && !permanent_lock
            |=> !regs.status_guard_high && !regs.four_lane_enable;
    endproperty
    a_guard_reset: assert property (p_guard_reset)
        else $error("reset value wrong");

    property p_permanent_hold;
        @(posedge clk_sys)
        permanent_lock |=> regs.status_guard_high;
    endproperty
    a_permanent_hold: assert property (p_permanent_hold)
        else $error("permanent guard released");

    property p_lock_on_last;
        @(posedge clk_sys) disable iff (sys_rst)
        sec_program_pulse && sec_program_byte == `SEC_LAST_BYTE &&
            sec_program_index != `SEC_FACTORY_REG
            |=> regs.security_lock_flags[$past(sec_program_index) - 2'h1];
    endproperty
    a_lock_on_last: assert property (p_lock_on_last)
        else $error("last byte did not lock register");

endmodule
`default_nettype wire

/* File: tb/spi_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Mode 0 host: the clock rests low between frames and only runs inside them.
module spi_host_model (
    output logic link_clk,
    output logic chip_select_n,
    output logic link_mosi,
    input wire logic link_miso,
    input wire logic link_miso_oe_n
);
    localparam time half_period = 24ns;
    logic oe_seen_n;

    initial begin
        link_clk = 1'b0;
        chip_select_n = 1'b1;
        link_mosi = 1'b1;
        oe_seen_n = 1'b1;
    end

    // Sends an opcode and one data byte, MSB first, and captures the reply.
    task automatic xfer(input logic [7:0] op, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {op, wdata};
        rdata = 8'h00;
        #3ns chip_select_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            link_mosi = frame[i];
            #half_period link_clk = 1'b1;
            if (i < 8) begin
                rdata[i] = link_miso;
            end
            if (i == 4) begin
                oe_seen_n = link_miso_oe_n;
            end
            #half_period link_clk = 1'b0;
        end
        #half_period chip_select_n = 1'b1;
        // A released line shows the opposite level, not a stale bit.
        link_mosi = ~link_mosi;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_status_two_bank.sv */
`timescale 1ns/100ps
`default_nettype none
`include "flash_status_two_regs.svh"

`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    fails++; $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
    end end

module tb_status_two_bank;
    logic clk_sys, sys_rst, link_clk, chip_select_n, link_mosi;
    logic link_miso, link_miso_oe_n, write_guard_pin_n, pause_pin_n;
    logic status_guard_low, status_guard_permanent, write_enable_latch;
    logic region_selected, sec_program_pulse, opcode_valid;
    logic [1:0] sec_program_index;
    logic [6:0] sec_program_byte;
    logic [7:0] opcode_seen, status_two_value, rd;
    logic sec_write_blocked, array_write_blocked, command_allowed;
    logic guard_pin_active, pause_pin_active, quad_lanes_active;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] quad_ops [6] = '{`OP_QUAD_OUT_READ, `OP_FETCH_READ,
        `OP_WORD_QUAD_READ, `OP_QUAD_PROGRAM, `OP_BURST_WRAP, `OP_QUAD_ID};

    status_two_bank u_status_two_bank (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .link_clk(link_clk),
        .chip_select_n(chip_select_n), .link_mosi(link_mosi),
        .link_miso(link_miso), .link_miso_oe_n(link_miso_oe_n),
        .write_guard_pin_n(write_guard_pin_n), .pause_pin_n(pause_pin_n),
        .status_guard_low(status_guard_low),
        .status_guard_permanent(status_guard_permanent),
        .write_enable_latch(write_enable_latch),
        .region_selected(region_selected),
        .sec_program_pulse(sec_program_pulse),
        .sec_program_index(sec_program_index),
        .sec_program_byte(sec_program_byte), .opcode_seen(opcode_seen),
        .opcode_valid(opcode_valid), .sec_write_blocked(sec_write_blocked),
        .array_write_blocked(array_write_blocked),
        .command_allowed(command_allowed),
        .guard_pin_active(guard_pin_active),
        .pause_pin_active(pause_pin_active),
        .quad_lanes_active(quad_lanes_active),
        .status_two_value(status_two_value)
    );

    spi_host_model u_spi_host_model (
        .link_clk(link_clk), .chip_select_n(chip_select_n),
        .link_mosi(link_mosi), .link_miso(link_miso),
        .link_miso_oe_n(link_miso_oe_n)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5ns clk_sys = ~clk_sys;
    end

    // Generous ceiling: the whole sequence needs a few thousand cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 50000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Write lands a few system cycles after the frame; ten is ample.
    task automatic wr_check(input logic [7:0] d, input logic [7:0] exp);
        u_spi_host_model.xfer(`OP_WRITE_SR2, d, rd);
        cyc(10);
        `CHECK(status_two_value, exp)
        u_spi_host_model.xfer(`OP_READ_SR2, 8'h00, rd);
        `CHECK(rd, exp)
        `CHECK(u_spi_host_model.oe_seen_n, 1'b0)
        cyc(2);
        `CHECK(link_miso_oe_n, 1'b1)
    endtask

    task automatic pulse_rst();
        @(negedge clk_sys) sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(1);
    endtask

    task automatic cmd(input logic [7:0] op, input logic exp);
        @(negedge clk_sys) opcode_seen = op;
        opcode_valid = 1'b1;
        @(negedge clk_sys) opcode_valid = 1'b0;
        `CHECK(command_allowed, exp)
    endtask

    task automatic test_reset_and_pins();
        `CHECK(status_two_value, 8'h00)
        `CHECK(guard_pin_active, 1'b0)
        `CHECK(quad_lanes_active, 1'b0)
        @(negedge clk_sys) write_guard_pin_n = 1'b0;
        pause_pin_n = 1'b0;
        cyc(3);
        `CHECK(guard_pin_active, 1'b1)
        `CHECK(pause_pin_active, 1'b1)
        write_guard_pin_n = 1'b1;
        pause_pin_n = 1'b1;
        cyc(3);
        `CHECK(pause_pin_active, 1'b0)
        foreach (quad_ops[i]) cmd(quad_ops[i], 1'b0);
        cmd(8'h03, 1'b1);
    endtask

    task automatic test_writes();
        write_enable_latch = 1'b0;
        wr_check(8'h42, 8'h00);
        write_enable_latch = 1'b1;
        wr_check(8'h7E, 8'h42);
        write_guard_pin_n = 1'b0;
        pause_pin_n = 1'b0;
        cyc(3);
        `CHECK(quad_lanes_active, 1'b1)
        `CHECK(guard_pin_active, 1'b0)
        `CHECK(pause_pin_active, 1'b0)
        write_guard_pin_n = 1'b1;
        pause_pin_n = 1'b1;
        foreach (quad_ops[i]) cmd(quad_ops[i], 1'b1);
        cmd(8'h03, 1'b1);
    endtask

    task automatic test_complement();
        logic [1:0] combo;
        for (int k = 0; k < 4; k++) begin
            combo = 2'(k);
            wr_check({1'b0, combo[1], 6'h00}, {1'b0, combo[1], 6'h00});
            @(negedge clk_sys) region_selected = combo[0];
            cyc(3);
            `CHECK(array_write_blocked, combo[0] ^ combo[1])
        end
        `CHECK(status_two_value, 8'h40)
    endtask

    task automatic test_guards();
        wr_check(8'h00, 8'h00);
        status_guard_low = 1'b1;
        write_guard_pin_n = 1'b0;
        wr_check(8'h40, 8'h00);
        write_guard_pin_n = 1'b1;
        wr_check(8'h40, 8'h40);
        status_guard_low = 1'b0;
        wr_check(8'h01, 8'h01);
        wr_check(8'h42, 8'h01);
        pulse_rst();
        `CHECK(status_two_value, 8'h00)
        wr_check(8'h02, 8'h02);
        status_guard_low = 1'b1;
        status_guard_permanent = 1'b1;
        wr_check(8'h01, 8'h01);
        wr_check(8'h42, 8'h01);
        pulse_rst();
        `CHECK(status_two_value, 8'h01)
        status_guard_permanent = 1'b0;
        pulse_rst();
        `CHECK(status_two_value, 8'h00)
        status_guard_low = 1'b0;
    endtask

    task automatic prog(input logic [1:0] idx, input logic [6:0] b);
        @(negedge clk_sys) sec_program_index = idx;
        sec_program_byte = b;
        sec_program_pulse = 1'b1;
        @(negedge clk_sys) sec_program_pulse = 1'b0;
        cyc(2);
    endtask

    task automatic test_locks();
        logic [2:0] exp_locks;
        exp_locks = 3'h0;
        `CHECK(status_two_value[5:3], 3'h0)
        prog(2'h0, `SEC_LAST_BYTE);
        `CHECK(sec_write_blocked, 1'b1)
        `CHECK(status_two_value[5:3], 3'h0)
        prog(2'h2, 7'h7E);
        `CHECK(sec_write_blocked, 1'b0)
        `CHECK(status_two_value[5:3], 3'h0)
        for (int i = 1; i < 4; i++) begin
            prog(2'(i), `SEC_LAST_BYTE);
            exp_locks[i - 1] = 1'b1;
            `CHECK(status_two_value[5:3], exp_locks)
            `CHECK(sec_write_blocked, 1'b1)
        end
        pulse_rst();
        `CHECK(status_two_value[5:3], 3'h7)
    endtask

    initial begin
        sys_rst = 1'b1;
        write_guard_pin_n = 1'b1;
        pause_pin_n = 1'b1;
        status_guard_low = 1'b0;
        status_guard_permanent = 1'b0;
        write_enable_latch = 1'b0;
        region_selected = 1'b0;
        sec_program_pulse = 1'b0;
        sec_program_index = 2'h0;
        sec_program_byte = 7'h00;
        opcode_seen = 8'h00;
        opcode_valid = 1'b0;
        cyc(8);
        sys_rst = 1'b0;
        cyc(2);
        test_reset_and_pins();
        test_writes();
        test_complement();
        test_guards();
        test_locks();
        wrap_up();
    end
endmodule
`default_nettype wire
